// ### common/tool_pos_defines.vh
// Constants for the tool position decoder: register map, field layout,
// reset values. Assumes a 32-bit APB slave with word-aligned registers.
`ifndef TOOL_POS_DEFINES_VH
`define TOOL_POS_DEFINES_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_CTRL 8'h00
`define OFS_CFG 8'h04
`define OFS_TOOLCMD 8'h08
`define OFS_STATUS 8'h0c
`define OFS_RAW 8'h10
`define OFS_IRQ_STAT 8'h14
`define OFS_IRQ_MASK 8'h18
`define OFS_MACRO_VARS 8'h1c
`define OFS_MACRO_DONE 8'h20
`define OFS_TABLE_BASE 8'h40
`define TABLE_ADDR_HI 2'h1

// ----------------------------------------
// Field layout
// ----------------------------------------
`define CTRL_TYPE_LSB 0
`define CTRL_TYPE_MSB 3
`define CTRL_METHOD_BIT 4
`define CFG_TOOLS_LSB 0
`define CFG_TOOLS_MSB 4
`define CFG_LINES_LSB 8
`define CFG_LINES_MSB 11
`define CMD_TOOL_LSB 0
`define CMD_TOOL_MSB 4
`define CMD_OFS_LSB 8
`define CMD_OFS_MSB 15
`define ST_VALID_BIT 8
`define ST_BUSY_BIT 9
`define ST_MACRO_BIT 10
`define ST_STATE_LSB 12
`define ST_STATE_MSB 14

// Interrupt status bits
`define IRQ_MISMATCH 0
`define IRQ_DONE 1
`define IRQ_MOVED 2
`define IRQ_LOST 3
`define IRQ_W 4

// ----------------------------------------
// Values
// ----------------------------------------
`define TYPE_LINE_UP 4'h0
`define TYPE_MACRO 4'h9
`define METHOD_DIRECT 1'b0
`define METHOD_TABLE 1'b1
`define CTRL_RESET 5'h00
`define CFG_TOOLS_RESET 5'h04
`define CFG_LINES_RESET 4'h4
`define TABLE_MAX_TOOLS 5'h10

`endif

// ### rtl/code_table_mem.v
// Per-tool expected code storage: one write port, two registered read ports.
// Assumes a single clock; read data appear one edge after the address.
`timescale 1ns/1ns
`default_nettype none

module code_table_mem #(
    parameter DEPTH = 16,
    parameter AW = 4,
    parameter DW = 8
) (
    input wire clk, // System clock
    input wire rst_n, // Async reset, active low
    input wire wr_en, // Write strobe
    input wire [AW-1:0] wr_addr, // Write entry
    input wire [DW-1:0] wr_data, // Write value
    input wire [AW-1:0] rd_a_addr, // Scan read entry
    output reg [DW-1:0] rd_a_data, // Scan read value
    input wire [AW-1:0] rd_b_addr, // Bus read entry
    output reg [DW-1:0] rd_b_data // Bus read value
);

reg [DW-1:0] mem_reg [0:DEPTH-1];
integer i;

// ----------------------------------------
// Storage, cleared at reset so a scan never compares against unknowns
// ----------------------------------------
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        for (i = 0; i < DEPTH; i = i + 1) begin
            mem_reg[i] <= {DW{1'b0}};
        end
        rd_a_data <= {DW{1'b0}};
        rd_b_data <= {DW{1'b0}};
    end else begin
        if (wr_en) begin
            mem_reg[wr_addr] <= wr_data;
        end
        rd_a_data <= mem_reg[rd_a_addr];
        rd_b_data <= mem_reg[rd_b_addr];
    end
end

endmodule
`default_nettype wire

// ### rtl/tool_position_decoder.v
// Turret tool position decoder with APB register access and a
// macro-driven tool change handshake toward the tool change sequencer.
// Assumes sensor lines are asynchronous pins; macro_done comes from
// logic on clk.
//
// The implementer's own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "tool_pos_defines.vh"

// What this block does
// - The check-method bit picks direct one-line-per-tool decoding at 0 and table look-up at 1.
// - With the line-up tool post type (0) the check-method bit is ignored and direct decoding is used.
// - Direct decoding needs tool count equal to line count, else a tool change raises a mismatch.
// - In direct decoding a tool is seen only when its own line is low and all other used lines high.
// - Table decoding holds one expected code per tool for up to 16 tools, any line count.
// - The observed code is the used lines with the highest line as MSB, compared with each entry.
// - The raw sensor pattern is readable for diagnosis.
// - With tool post type 9 every accepted tool command starts the user tool change macro.
// - A macro change updates tool and offset, writes the macro variables, calls, waits, then ends.
module tool_position_decoder #(
    parameter LINES = 8,
    parameter TOOLS = 16,
    parameter TW = 5,
    parameter OW = 8
) (
    input wire clk, // System clock, 250 MHz
    input wire rst_n, // Async reset, active low
    input wire [LINES-1:0] tool_sense_in, // Sensor lines, bit 0 is line one
    input wire psel, // APB select
    input wire penable, // APB enable
    input wire pwrite, // APB direction
    input wire [7:0] paddr, // APB byte address
    input wire [31:0] pwdata, // APB write data
    output reg [31:0] prdata, // APB read data
    output reg pready, // APB ready
    output reg pslverr, // APB error for unmapped address
    output reg [TW-1:0] tool_number, // Decoded tool, 0 when invalid
    output reg tool_valid, // Decoded position is valid
    output reg [TW-1:0] target_tool_variable, // Macro variable: target tool
    output reg [OW-1:0] target_offset_variable, // Macro variable: target offset
    output reg nose_update, // Pulse: recompute tool nose coordinates
    output reg macro_req, // Level: user macro running
    input wire macro_done, // Pulse: user macro finished
    output reg irq // Level interrupt
);

localparam ST_IDLE = 3'h0;
localparam ST_UPDATE = 3'h1;
localparam ST_VARS = 3'h2;
localparam ST_CALL = 3'h3;
localparam ST_WAIT = 3'h4;
localparam ST_FINISH = 3'h5;

// ----------------------------------------
// Sensor synchronisers
// ----------------------------------------
reg [LINES-1:0] sync1_reg;
reg [LINES-1:0] sync2_reg;
reg [LINES-1:0] sync3_reg;
reg [LINES-1:0] stable_reg;

always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        sync1_reg <= {LINES{1'b1}};
        sync2_reg <= {LINES{1'b1}};
        sync3_reg <= {LINES{1'b1}};
        stable_reg <= {LINES{1'b1}};
    end else begin
        sync1_reg <= tool_sense_in;
        sync2_reg <= sync1_reg;
        sync3_reg <= sync2_reg;
        stable_reg <= (sync3_reg & ~(sync2_reg ^ sync3_reg)) | (stable_reg & (sync2_reg ^ sync3_reg));
    end
end

// Per-line update only when stages two and three agree
wire [LINES-1:0] settled;
genvar g;
generate
    for (g = 0; g < LINES; g = g + 1) begin : g_settle
        assign settled[g] = (sync2_reg[g] == sync3_reg[g]) ? sync3_reg[g] : stable_reg[g];
    end
endgenerate

// ----------------------------------------
// Configuration registers
// ----------------------------------------
reg [3:0] type_reg;
reg method_reg;
reg [TW-1:0] tools_cfg_reg;
reg [3:0] lines_cfg_reg;
reg [`IRQ_W-1:0] irq_stat_reg;
reg [`IRQ_W-1:0] irq_mask_reg;

// Lines at or above the configured count are dropped from the code
wire [LINES-1:0] line_mask;
generate
    for (g = 0; g < LINES; g = g + 1) begin : g_mask
        assign line_mask[g] = (g < lines_cfg_reg);
    end
endgenerate

wire method_eff = (type_reg == `TYPE_LINE_UP) ? `METHOD_DIRECT : method_reg;
wire [LINES-1:0] obs_code = settled & line_mask;
wire [TW-1:0] tool_lim = (tools_cfg_reg == {TW{1'b0}} || tools_cfg_reg > `TABLE_MAX_TOOLS)
    ? `TABLE_MAX_TOOLS : tools_cfg_reg;
wire count_match = (tools_cfg_reg == {1'b0, lines_cfg_reg});

// ----------------------------------------
// Direct decode: exactly one used line low
// ----------------------------------------
wire [LINES-1:0] active_low = ~settled & line_mask;
wire one_hot = (active_low != {LINES{1'b0}}) &&
    ((active_low & (active_low - {{(LINES-1){1'b0}}, 1'b1})) == {LINES{1'b0}});

function [TW-1:0] low_line_tool;
    input [LINES-1:0] act;
    integer k;
    begin
        low_line_tool = {TW{1'b0}};
        for (k = 0; k < LINES; k = k + 1) begin
            if (act[k]) begin
                low_line_tool = k[TW-1:0] + {{(TW-1){1'b0}}, 1'b1};
            end
        end
    end
endfunction

wire direct_valid = one_hot && count_match;
wire [TW-1:0] direct_tool = low_line_tool(active_low);

// ----------------------------------------
// Table scan: one entry per cycle through the registered memory
// ----------------------------------------
reg [3:0] scan_idx_reg;
reg [3:0] scan_tag_reg;
reg [LINES-1:0] snap_reg;
reg found_reg;
reg [TW-1:0] found_tool_reg;
reg table_valid_reg;
reg [TW-1:0] table_tool_reg;
wire [LINES-1:0] scan_data;
wire [LINES-1:0] bus_tab_data;
wire [TW-1:0] tag_tool = {1'b0, scan_tag_reg} + {{(TW-1){1'b0}}, 1'b1};
wire scan_hit = (scan_data == snap_reg);
wire scan_last = (tag_tool == tool_lim);

always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        scan_idx_reg <= 4'h0;
        scan_tag_reg <= 4'h0;
        snap_reg <= {LINES{1'b0}};
        found_reg <= 1'b0;
        found_tool_reg <= {TW{1'b0}};
        table_valid_reg <= 1'b0;
        table_tool_reg <= {TW{1'b0}};
    end else begin
        scan_tag_reg <= scan_idx_reg;
        if ({1'b0, scan_idx_reg} + {{(TW-1){1'b0}}, 1'b1} >= tool_lim) begin
            scan_idx_reg <= 4'h0;
        end else begin
            scan_idx_reg <= scan_idx_reg + 4'h1;
        end
        if (scan_idx_reg == 4'h0) begin
            snap_reg <= obs_code;
        end
        // First matching entry of a pass wins
        if (scan_tag_reg == 4'h0) begin
            found_reg <= scan_hit;
            found_tool_reg <= tag_tool;
        end else if (scan_hit && !found_reg) begin
            found_reg <= 1'b1;
            found_tool_reg <= tag_tool;
        end
        if (scan_last) begin
            if (scan_tag_reg == 4'h0 || (scan_hit && !found_reg)) begin
                table_valid_reg <= scan_hit;
                table_tool_reg <= tag_tool;
            end else begin
                table_valid_reg <= found_reg;
                table_tool_reg <= found_tool_reg;
            end
        end
    end
end

// ----------------------------------------
// APB slave: one wait state, access completes on the second enable cycle
// ----------------------------------------
wire access = psel && penable;
wire done_edge = access && pready;
wire wr_fire = done_edge && pwrite;
wire rd_fire = done_edge && !pwrite;
wire tab_hit = (paddr[7:6] == `TABLE_ADDR_HI) && (paddr[1:0] == 2'b00);
wire [3:0] tab_idx = paddr[5:2];
wire known = tab_hit || paddr == `OFS_CTRL || paddr == `OFS_CFG || paddr == `OFS_TOOLCMD ||
    paddr == `OFS_STATUS || paddr == `OFS_RAW || paddr == `OFS_IRQ_STAT ||
    paddr == `OFS_IRQ_MASK || paddr == `OFS_MACRO_VARS || paddr == `OFS_MACRO_DONE;
wire cmd_wr = wr_fire && paddr == `OFS_TOOLCMD;
wire sw_done = wr_fire && paddr == `OFS_MACRO_DONE;
wire stat_rd = rd_fire && paddr == `OFS_IRQ_STAT;

code_table_mem #(
    .DEPTH(TOOLS),
    .AW(4),
    .DW(LINES)
) u_table (
    .clk(clk),
    .rst_n(rst_n),
    .wr_en(wr_fire && tab_hit),
    .wr_addr(tab_idx),
    .wr_data(pwdata[LINES-1:0]),
    .rd_a_addr(scan_idx_reg),
    .rd_a_data(scan_data),
    .rd_b_addr(tab_idx),
    .rd_b_data(bus_tab_data)
);

// ----------------------------------------
// Tool change sequence
// ----------------------------------------
reg [2:0] state_reg;
reg [2:0] state_next;
reg [TW-1:0] cmd_tool_reg;
reg [OW-1:0] cmd_ofs_reg;
reg [TW-1:0] cur_tool_reg;
reg [OW-1:0] cur_ofs_reg;

always @* begin
    state_next = state_reg;
    case (state_reg)
        ST_IDLE: begin
            // Direct method refuses a change while counts disagree
            if (cmd_wr && !(method_eff == `METHOD_DIRECT && !count_match)) begin
                state_next = ST_UPDATE;
            end
        end
        ST_UPDATE: begin
            state_next = (type_reg == `TYPE_MACRO) ? ST_VARS : ST_FINISH;
        end
        ST_VARS: state_next = ST_CALL;
        ST_CALL: state_next = ST_WAIT;
        ST_WAIT: begin
            if (macro_done || sw_done) begin
                state_next = ST_FINISH;
            end
        end
        ST_FINISH: state_next = ST_IDLE;
        default: state_next = ST_IDLE;
    endcase
end

always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        state_reg <= ST_IDLE;
        cmd_tool_reg <= {TW{1'b0}};
        cmd_ofs_reg <= {OW{1'b0}};
        cur_tool_reg <= {TW{1'b0}};
        cur_ofs_reg <= {OW{1'b0}};
        target_tool_variable <= {TW{1'b0}};
        target_offset_variable <= {OW{1'b0}};
        nose_update <= 1'b0;
        macro_req <= 1'b0;
    end else begin
        state_reg <= state_next;
        nose_update <= 1'b0;
        if (cmd_wr && state_reg == ST_IDLE) begin
            cmd_tool_reg <= pwdata[`CMD_TOOL_MSB:`CMD_TOOL_LSB];
            cmd_ofs_reg <= pwdata[`CMD_OFS_MSB:`CMD_OFS_LSB];
        end
        if (state_reg == ST_UPDATE) begin
            cur_tool_reg <= cmd_tool_reg;
            cur_ofs_reg <= cmd_ofs_reg;
            nose_update <= 1'b1;
        end
        if (state_reg == ST_VARS) begin
            target_tool_variable <= cur_tool_reg;
            target_offset_variable <= cur_ofs_reg;
        end
        if (state_reg == ST_CALL) begin
            macro_req <= 1'b1;
        end else if (state_reg == ST_WAIT && state_next == ST_FINISH) begin
            macro_req <= 1'b0;
        end
    end
end

// ----------------------------------------
// Registers, decoded result and interrupts
// ----------------------------------------
wire sel_valid = (method_eff == `METHOD_TABLE) ? table_valid_reg : direct_valid;
wire [TW-1:0] sel_tool = (method_eff == `METHOD_TABLE) ? table_tool_reg : direct_tool;
reg [`IRQ_W-1:0] ev;
reg [`IRQ_W-1:0] irq_stat_next;
reg [31:0] rdata;

always @* begin
    ev = {`IRQ_W{1'b0}};
    ev[`IRQ_MISMATCH] = cmd_wr && state_reg == ST_IDLE &&
        method_eff == `METHOD_DIRECT && !count_match;
    ev[`IRQ_DONE] = (state_reg == ST_FINISH);
    ev[`IRQ_MOVED] = sel_valid && (!tool_valid || sel_tool != tool_number);
    ev[`IRQ_LOST] = !sel_valid && tool_valid;
    // Set wins over the read clear
    irq_stat_next = (stat_rd ? (irq_stat_reg & ~prdata[`IRQ_W-1:0]) : irq_stat_reg) | ev;
end

always @* begin
    rdata = 32'h0000_0000;
    if (tab_hit) begin
        rdata[LINES-1:0] = bus_tab_data;
    end else begin
        case (paddr)
            `OFS_CTRL: begin
                rdata[`CTRL_TYPE_MSB:`CTRL_TYPE_LSB] = type_reg;
                rdata[`CTRL_METHOD_BIT] = method_reg;
            end
            `OFS_CFG: begin
                rdata[`CFG_TOOLS_MSB:`CFG_TOOLS_LSB] = tools_cfg_reg;
                rdata[`CFG_LINES_MSB:`CFG_LINES_LSB] = lines_cfg_reg;
            end
            `OFS_TOOLCMD: begin
                rdata[`CMD_TOOL_MSB:`CMD_TOOL_LSB] = cur_tool_reg;
                rdata[`CMD_OFS_MSB:`CMD_OFS_LSB] = cur_ofs_reg;
            end
            `OFS_STATUS: begin
                rdata[TW-1:0] = tool_number;
                rdata[`ST_VALID_BIT] = tool_valid;
                rdata[`ST_BUSY_BIT] = (state_reg != ST_IDLE);
                rdata[`ST_MACRO_BIT] = macro_req;
                rdata[`ST_STATE_MSB:`ST_STATE_LSB] = state_reg;
            end
            `OFS_RAW: rdata[LINES-1:0] = stable_reg;
            `OFS_IRQ_STAT: rdata[`IRQ_W-1:0] = irq_stat_reg;
            `OFS_IRQ_MASK: rdata[`IRQ_W-1:0] = irq_mask_reg;
            `OFS_MACRO_VARS: begin
                rdata[`CMD_TOOL_MSB:`CMD_TOOL_LSB] = target_tool_variable;
                rdata[`CMD_OFS_MSB:`CMD_OFS_LSB] = target_offset_variable;
            end
            default: rdata = 32'h0000_0000;
        endcase
    end
end

always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        type_reg <= `TYPE_LINE_UP;
        method_reg <= `METHOD_DIRECT;
        tools_cfg_reg <= `CFG_TOOLS_RESET;
        lines_cfg_reg <= `CFG_LINES_RESET;
        irq_stat_reg <= {`IRQ_W{1'b0}};
        irq_mask_reg <= {`IRQ_W{1'b0}};
        irq <= 1'b0;
        tool_number <= {TW{1'b0}};
        tool_valid <= 1'b0;
        prdata <= 32'h0000_0000;
        pready <= 1'b0;
        pslverr <= 1'b0;
    end else begin
        pready <= access && !pready;
        pslverr <= access && !pready && !known;
        if (access && !pready) begin
            prdata <= rdata;
        end
        if (wr_fire && paddr == `OFS_CTRL) begin
            type_reg <= pwdata[`CTRL_TYPE_MSB:`CTRL_TYPE_LSB];
            method_reg <= pwdata[`CTRL_METHOD_BIT];
        end
        if (wr_fire && paddr == `OFS_CFG) begin
            tools_cfg_reg <= pwdata[`CFG_TOOLS_MSB:`CFG_TOOLS_LSB];
            lines_cfg_reg <= pwdata[`CFG_LINES_MSB:`CFG_LINES_LSB];
        end
        if (wr_fire && paddr == `OFS_IRQ_MASK) begin
            irq_mask_reg <= pwdata[`IRQ_W-1:0];
        end
        irq_stat_reg <= irq_stat_next;
        irq <= |(irq_stat_next & irq_mask_reg);
        tool_valid <= sel_valid;
        tool_number <= sel_valid ? sel_tool : {TW{1'b0}};
    end
end

endmodule
`default_nettype wire

// ### verification/tool_pos_chk.sv
// Port checker for the tool position decoder, bound into its top module.
// Assumes the APB master holds each request until pready is seen high.
`timescale 1ns/1ns
`default_nettype none

module tool_pos_chk #(
    parameter LINES = 8,
    parameter TW = 5,
    parameter OW = 8
) (
    input wire clk, // System clock
    input wire rst_n, // Async reset, active low
    input wire psel, // APB select
    input wire penable, // APB enable
    input wire pready, // APB ready
    input wire pslverr, // APB error
    input wire [TW-1:0] tool_number, // Decoded tool
    input wire tool_valid, // Decoded position valid
    input wire [TW-1:0] target_tool_variable, // Macro variable: tool
    input wire [OW-1:0] target_offset_variable, // Macro variable: offset
    input wire nose_update, // Nose recompute pulse
    input wire macro_req, // User macro running
    input wire macro_done // User macro finished
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // ----------------------------------------
    // Decode result
    // ----------------------------------------
    a_invalid_zero: assert property (!tool_valid |-> tool_number == 0)
        else $error("tool number not zero while invalid");
    a_valid_range: assert property (tool_valid |-> tool_number inside {[1:16]})
        else $error("valid tool number out of range");

    // ----------------------------------------
    // Macro change sequence
    // ----------------------------------------
    a_nose_pulse: assert property (nose_update |=> !nose_update)
        else $error("nose update longer than one cycle");
    a_call_after_nose: assert property ($rose(macro_req) |-> $past(nose_update, 2))
        else $error("macro called without prior nose update");
    a_vars_before_call: assert property ($rose(macro_req) |->
        $stable(target_tool_variable) && $stable(target_offset_variable))
        else $error("macro variables moved at call");
    a_macro_ends: assert property (macro_req && macro_done |=> !macro_req)
        else $error("macro request kept after done");
    a_macro_waits: assert property (macro_req && !macro_done |=> macro_req)
        else $error("macro request dropped before done");

    // ----------------------------------------
    // Register bus
    // ----------------------------------------
    a_ready_second: assert property (psel && penable && !pready |=> pready)
        else $error("pready missing in second access cycle");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
endmodule

bind tool_position_decoder tool_pos_chk #(.LINES(LINES), .TW(TW), .OW(OW)) i_tool_pos_chk (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pready(pready),
    .pslverr(pslverr), .tool_number(tool_number), .tool_valid(tool_valid),
    .target_tool_variable(target_tool_variable),
    .target_offset_variable(target_offset_variable), .nose_update(nose_update),
    .macro_req(macro_req), .macro_done(macro_done));
`default_nettype wire

// ### verification/tool_turret_model.sv
// Turret sensors and tool change sequencer seen from the decoder.
// Assumes the bench sets the shown position code and the macro run time.
`timescale 1ns/1ns
`default_nettype none

module tool_turret_model #(
    parameter LINES = 8
) (
    input wire logic clk, // System clock
    input wire logic rst_n, // Async reset, active low
    input wire logic [LINES-1:0] pattern, // Shown code, bit 0 is line one
    input wire logic [3:0] done_delay, // Macro run time in cycles
    input wire logic macro_req, // User macro running
    output logic [LINES-1:0] tool_sense_in, // Sensor lines
    output logic macro_done // Macro finished pulse
);
    logic [4:0] cnt;

    assign tool_sense_in = pattern;

    // Counter parks at its top so one request yields exactly one pulse
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 5'h00;
            macro_done <= 1'b0;
        end else begin
            macro_done <= 1'b0;
            if (!macro_req) begin
                cnt <= 5'h00;
            end else if (cnt != 5'h1f) begin
                cnt <= cnt + 5'h01;
                macro_done <= (cnt == {1'b0, done_delay});
            end
        end
    end
endmodule
`default_nettype wire

// ### verification/test_tool_position_decoder.sv
// Self-checking bench for the tool position decoder, driven over APB.
// Assumes the design header register map and the turret model.
`timescale 1ns/1ns
`default_nettype none
`include "tool_pos_defines.vh"

module test_tool_position_decoder;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00, pattern = 8'hff;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, tool_valid, nose_update, macro_req, macro_done, irq;
    logic [4:0] tool_number, target_tool_variable, t;
    logic [7:0] target_offset_variable, tool_sense_in, o;
    logic [3:0] done_delay = 4'h0;
    logic [3:0] code [8] = '{4'h2, 4'h8, 4'h1, 4'h4, 4'h7, 4'hd, 4'hb, 4'he};
    logic [64:0] exq [$];
    logic [64:0] nt;
    logic [12:0] mq [$];
    int miscompares = 0, n_tests = 0, k;

    always #2 clk = ~clk;

    tool_position_decoder i_tool_position_decoder (.clk(clk), .rst_n(rst_n),
        .tool_sense_in(tool_sense_in), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .tool_number(tool_number), .tool_valid(tool_valid),
        .target_tool_variable(target_tool_variable),
        .target_offset_variable(target_offset_variable), .nose_update(nose_update),
        .macro_req(macro_req), .macro_done(macro_done), .irq(irq));

    tool_turret_model i_tool_turret_model (.clk(clk), .rst_n(rst_n), .pattern(pattern),
        .done_delay(done_delay), .macro_req(macro_req), .tool_sense_in(tool_sense_in),
        .macro_done(macro_done));

    // ----------------------------------------
    // Reporting and bus tasks
    // ----------------------------------------
    task end_of_test;
        $display("Counts: %0d compared, %0d mismatched", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask

    task timeout;
        chk("wait", 32'h1, 32'h0);
        end_of_test();
    endtask

    // Request held until pready is sampled high; the monitor judges the answer
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
             input logic [31:0] e, input logic [31:0] m, input logic er);
        exq.push_back({er, m, e});
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) timeout();
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0, 32'h0, 1'b0);
    endtask

    task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        apb(1'b0, a, 32'h0, e, m, 1'b0);
    endtask

    // Covers two full table scans plus the input synchroniser
    task settle;
        repeat (48) @(posedge clk);
    endtask

    task wait_irq;
        k = 0;
        while (irq !== 1'b1 && k < 200) begin
            @(posedge clk);
            k++;
        end
        if (irq !== 1'b1) timeout();
    endtask

    // ----------------------------------------
    // Result monitors
    // ----------------------------------------
    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1) begin
            nt = exq.pop_front();
            chk("prdata", nt[31:0], prdata & nt[63:32]);
            chk("pslverr", {31'h0, nt[64]}, {31'h0, pslverr});
        end
    end

    always @(posedge clk) begin
        if (rst_n && $rose(macro_req)) begin
            if (mq.size() == 0) chk("macro start", 32'h0, 32'h1);
            else chk("macro vars", {19'h0, mq.pop_front()},
                {19'h0, target_tool_variable, target_offset_variable});
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        k = $urandom(28384);
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(`OFS_CTRL, 32'h0, 32'h1f);
        rd(`OFS_CFG, 32'h404, 32'hf1f);
        rd(`OFS_IRQ_MASK, 32'h0, 32'hf);
        apb(1'b0, 8'h3c, 32'h0, 32'h0, 32'hffffffff, 1'b1);
        apb(1'b1, 8'h3c, 32'h5, 32'h0, 32'h0, 1'b1);
        $display("test reset values done");
        wr(`OFS_CTRL, 32'h1);
        for (int i = 1; i <= 4; i++) begin
            pattern <= ~(8'h01 << (i - 1));
            settle();
            rd(`OFS_STATUS, 32'h100 | i, 32'h11f);
            rd(`OFS_RAW, {24'h0, pattern}, 32'hff);
        end
        pattern <= 8'hfc;
        settle();
        rd(`OFS_STATUS, 32'h0, 32'h11f);
        wr(`OFS_CTRL, 32'h10);
        pattern <= 8'hfb;
        settle();
        rd(`OFS_STATUS, 32'h103, 32'h11f);
        wr(`OFS_CTRL, 32'h11);
        settle();
        rd(`OFS_STATUS, 32'h0, 32'h11f);
        $display("test direct decode done");
        wr(`OFS_CTRL, 32'h13);
        wr(`OFS_CFG, 32'h408);
        for (int i = 0; i < 8; i++) wr(`OFS_TABLE_BASE + 8'(4 * i), {28'h0, code[i]});
        for (int i = 0; i < 8; i++) begin
            pattern <= {4'($urandom), code[i]};
            settle();
            rd(`OFS_STATUS, 32'h100 | (i + 1), 32'h11f);
        end
        pattern <= 8'h0f;
        settle();
        rd(`OFS_STATUS, 32'h0, 32'h11f);
        $display("test table decode done");
        wr(`OFS_CTRL, 32'h1);
        wr(`OFS_IRQ_MASK, 32'h1);
        wr(`OFS_TOOLCMD, 32'h2);
        wait_irq();
        rd(`OFS_IRQ_STAT, 32'h1, 32'h1);
        rd(`OFS_IRQ_STAT, 32'h0, 32'h1);
        chk("irq", 32'h0, {31'h0, irq});
        wr(`OFS_IRQ_MASK, 32'h0);
        wr(`OFS_TOOLCMD, 32'h2);
        repeat (8) @(posedge clk);
        chk("irq", 32'h0, {31'h0, irq});
        rd(`OFS_IRQ_STAT, 32'h1, 32'h1);
        $display("test count mismatch done");
        wr(`OFS_CFG, 32'h404);
        wr(`OFS_CTRL, 32'h9);
        wr(`OFS_IRQ_MASK, 32'h2);
        for (int i = 0; i < 3; i++) begin
            t = 5'($urandom_range(4, 1));
            o = 8'($urandom);
            done_delay <= 4'($urandom);
            mq.push_back({t, o});
            wr(`OFS_TOOLCMD, {16'h0, o, 3'h0, t});
            wait_irq();
            rd(`OFS_IRQ_STAT, 32'h2, 32'h2);
        end
        chk("macro runs", 32'h0, mq.size());
        wr(`OFS_CTRL, 32'h1);
        wr(`OFS_TOOLCMD, 32'h3);
        wait_irq();
        rd(`OFS_IRQ_STAT, 32'h2, 32'h2);
        $display("test macro change done");
        end_of_test();
    end
endmodule
`default_nettype wire
